// *** hdl/irq_aggregator_pkg.sv ***
// Purpose: Shared constants and carrier types of the interrupt aggregator.
// Assumes: 32-bit AXI4-Lite data, one register per aligned word.
// Notes:   Bit positions count from the least significant bit.

package irq_aggregator_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [31:0] STATUS_OFFSET     = 32'h0001_AC00;
	localparam logic [31:0] ENABLE_OFFSET     = 32'h0001_AC04;
	localparam logic [31:0] EVENT_OFFSET      = 32'h0001_AC08;
	localparam logic [31:0] EVENT_MASK_OFFSET = 32'h0001_AC0C;

	localparam logic [31:0] RESET_VALUE       = 32'h0000_0000;

	// ****************************************************************
	// Field layout
	// ****************************************************************
	localparam int NUM_PORTS      = 8;
	localparam int RESET_SYM_BIT  = 4;
	localparam int MCAST_EVT_BIT  = 5;
	localparam int TWO_WIRE_BIT   = 6;
	localparam int FABRIC_ERR_BIT = 7;
	localparam int MCAST_LAT_BIT  = 14;
	localparam int PORT_LSB       = 24;
	localparam int STRB_W         = 4;

	// Only these bits exist in the status and enable registers.
	localparam logic [31:0] DEFINED_BITS = 32'hFF00_40F0;

	// ****************************************************************
	// Bus answers
	// ****************************************************************
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************************************
	// Interrupt requests of the neighbouring source blocks
	// ****************************************************************
	typedef struct packed {
		logic [NUM_PORTS-1:0] port_irq;
		logic [NUM_PORTS-1:0] mcast_latency_err;
		logic [NUM_PORTS-1:0] fabric_port_error;
		logic                 two_wire_irq;
		logic [NUM_PORTS-1:0] mcast_event_irq;
		logic [NUM_PORTS-1:0] reset_symbol_irq;
	} source_req_s;

endpackage : irq_aggregator_pkg

// *** hdl/irq_aggregator.sv ***
// Purpose: Global interrupt aggregation of the switch utility unit.
// Assumes: Source requests come from logic on clk_i; AXI4-Lite slave.
// Notes:   The pin is open-drain style: value low, enable active low.
//
// Functional notes
// - Status bit shows live OR of source requests.
// - Request reaches pin only when enable set.
// - Bit 4 reports and gates reset symbols.
// - Bit 5 reports and gates multicast events.
// - Bit 6 reports and gates two-wire interrupt.
// - Bit 7 reports and gates fabric errors.
// - Bit 14 reports and gates multicast latency.
// - Bits 24..31 are ports 7 down to 0.
// - Status bits 0..3 reserved, read zero.
// - Status read-only, enable and event mask RW, event write-one-to-clear, others zero.
// - Fabric error clear removes its request.

`timescale 1ns/100ps

module irq_aggregator
	import irq_aggregator_pkg::*;
#(
	parameter int ADDR_W = 18
) (
	input  wire logic                        clk_i,
	input  wire logic                        sys_rst_i,
	input  wire irq_aggregator_pkg::source_req_s src_req_i,
	input  wire logic [ADDR_W-1:0]           s_axi_awaddr_i,
	input  wire logic                        s_axi_awvalid_i,
	output wire logic                        s_axi_awready_o,
	input  wire logic [31:0]                 s_axi_wdata_i,
	input  wire logic [3:0]                  s_axi_wstrb_i,
	input  wire logic                        s_axi_wvalid_i,
	output wire logic                        s_axi_wready_o,
	output wire logic [1:0]                  s_axi_bresp_o,
	output wire logic                        s_axi_bvalid_o,
	input  wire logic                        s_axi_bready_i,
	input  wire logic [ADDR_W-1:0]           s_axi_araddr_i,
	input  wire logic                        s_axi_arvalid_i,
	output wire logic                        s_axi_arready_o,
	output wire logic [31:0]                 s_axi_rdata_o,
	output wire logic [1:0]                  s_axi_rresp_o,
	output wire logic                        s_axi_rvalid_o,
	input  wire logic                        s_axi_rready_i,
	output wire logic                        int_pin_o,
	output wire logic                        int_pin_oe_n_o,
	output wire logic                        irq_o
);

	import irq_aggregator_pkg::*;

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	// The highest register sits at bit 16 of the byte address.
	if (ADDR_W < 17 || ADDR_W > 32) begin : g_addr_check
		$error("ADDR_W must lie between 17 and 32");
	end

	// ****************************************************************
	// Live status collection
	// ****************************************************************
	logic [31:0] global_interrupt_status;
	logic        reset_symbol_interrupt;
	logic        multicast_event_symbol_interrupt;
	logic        two_wire_interrupt;
	logic        fabric_transfer_error_interrupt;
	logic        multicast_latency_interrupt;
	logic [NUM_PORTS-1:0] port_field;

	// Each source block contributes one wire: its requests are ORed.
	assign reset_symbol_interrupt =
		|src_req_i.reset_symbol_irq;
	assign multicast_event_symbol_interrupt =
		|src_req_i.mcast_event_irq;
	assign two_wire_interrupt = src_req_i.two_wire_irq;
	// The per-port fabric flags drop when software clears them there.
	assign fabric_transfer_error_interrupt =
		|src_req_i.fabric_port_error;
	assign multicast_latency_interrupt =
		|src_req_i.mcast_latency_err;

	// Port 0 sits in the most significant bit of the field.
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port_map
		assign port_field[NUM_PORTS-1-p] =
			src_req_i.port_irq[p];
	end

	always_comb begin
		global_interrupt_status = RESET_VALUE;
		global_interrupt_status[RESET_SYM_BIT] =
			reset_symbol_interrupt;
		global_interrupt_status[MCAST_EVT_BIT] =
			multicast_event_symbol_interrupt;
		global_interrupt_status[TWO_WIRE_BIT] =
			two_wire_interrupt;
		global_interrupt_status[FABRIC_ERR_BIT] =
			fabric_transfer_error_interrupt;
		global_interrupt_status[MCAST_LAT_BIT] =
			multicast_latency_interrupt;
		global_interrupt_status[PORT_LSB +: NUM_PORTS] =
			port_field;
	end

	// ****************************************************************
	// Write channel capture
	// ****************************************************************
	logic              aw_full_q;
	logic              w_full_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic [ADDR_W-1:0] wr_addr_q;
	logic [31:0]       wr_data_q;
	logic [3:0]        wr_strb_q;

	wire aw_take  = s_axi_awvalid_i & ~aw_full_q;
	wire w_take   = s_axi_wvalid_i & ~w_full_q;
	// Address and data may arrive in either order; the write
	// happens once both are held and the last answer is gone.
	wire do_write = aw_full_q & w_full_q & ~bvalid_q;

	assign s_axi_awready_o = ~aw_full_q;
	assign s_axi_wready_o  = ~w_full_q;
	assign s_axi_bvalid_o  = bvalid_q;
	assign s_axi_bresp_o   = bresp_q;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			aw_full_q <= 1'b0;
			wr_addr_q <= '0;
		end else if (aw_take) begin
			aw_full_q <= 1'b1;
			wr_addr_q <= s_axi_awaddr_i;
		end else if (do_write) begin
			aw_full_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			w_full_q  <= 1'b0;
			wr_data_q <= RESET_VALUE;
			wr_strb_q <= '0;
		end else if (w_take) begin
			w_full_q  <= 1'b1;
			wr_data_q <= s_axi_wdata_i;
			wr_strb_q <= s_axi_wstrb_i;
		end else if (do_write) begin
			w_full_q  <= 1'b0;
		end
	end

	// ****************************************************************
	// Write decode
	// ****************************************************************
	wire [ADDR_W-3:0] wr_word = wr_addr_q[ADDR_W-1:2];
	wire wr_hit_status = wr_word == STATUS_OFFSET[ADDR_W-1:2];
	wire wr_hit_enable = wr_word == ENABLE_OFFSET[ADDR_W-1:2];
	wire wr_hit_event  = wr_word == EVENT_OFFSET[ADDR_W-1:2];
	wire wr_hit_emask  = wr_word == EVENT_MASK_OFFSET[ADDR_W-1:2];
	// Writes to the read-only status word are accepted and dropped.
	wire wr_mapped     = wr_hit_status | wr_hit_enable |
	                     wr_hit_event | wr_hit_emask;

	logic [31:0] wr_lanes;
	for (genvar b = 0; b < STRB_W; b++) begin : g_lanes
		assign wr_lanes[b*8 +: 8] = {8{wr_strb_q[b]}};
	end

	wire [31:0] wr_bits = wr_data_q & wr_lanes;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			bvalid_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Enable register
	// ****************************************************************
	logic [31:0] global_interrupt_enable_q;
	logic [31:0] global_interrupt_enable_d;

	// Only the defined bits hold state; all others stay zero.
	assign global_interrupt_enable_d =
		((global_interrupt_enable_q & ~wr_lanes) | wr_bits)
		& DEFINED_BITS;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			global_interrupt_enable_q <= RESET_VALUE;
		end else if (do_write && wr_hit_enable) begin
			global_interrupt_enable_q <= global_interrupt_enable_d;
		end
	end

	// ****************************************************************
	// External pin
	// ****************************************************************
	wire [31:0] gated_requests =
		global_interrupt_status & global_interrupt_enable_q;

	logic int_drive_q;

	// Registered so the pin never glitches while sources settle.
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			int_drive_q <= 1'b0;
		end else begin
			int_drive_q <= |gated_requests;
		end
	end

	// The pin is only ever pulled low; released it floats high.
	assign int_pin_o      = 1'b0;
	assign int_pin_oe_n_o = ~int_drive_q;

	// ****************************************************************
	// Sticky events and interrupt line
	// ****************************************************************
	logic [31:0] status_prev_q;
	logic [31:0] event_q;
	logic [31:0] event_d;
	logic [31:0] event_mask_q;

	wire [31:0] status_rise = global_interrupt_status & ~status_prev_q;
	wire [31:0] event_clear = (do_write && wr_hit_event) ?
	                          wr_bits : RESET_VALUE;

	// A rise in the clearing cycle survives: the set is applied last.
	assign event_d = (event_q & ~event_clear) | status_rise;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			status_prev_q <= RESET_VALUE;
			event_q       <= RESET_VALUE;
		end else begin
			status_prev_q <= global_interrupt_status;
			event_q       <= event_d;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			event_mask_q <= RESET_VALUE;
		end else if (do_write && wr_hit_emask) begin
			event_mask_q <= ((event_mask_q & ~wr_lanes) | wr_bits)
			                & DEFINED_BITS;
		end
	end

	assign irq_o = |(event_q & event_mask_q);

	// ****************************************************************
	// Read channel
	// ****************************************************************
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;

	wire ar_take = s_axi_arvalid_i & ~rvalid_q;

	wire [ADDR_W-3:0] rd_word = s_axi_araddr_i[ADDR_W-1:2];
	wire rd_hit_status = rd_word == STATUS_OFFSET[ADDR_W-1:2];
	wire rd_hit_enable = rd_word == ENABLE_OFFSET[ADDR_W-1:2];
	wire rd_hit_event  = rd_word == EVENT_OFFSET[ADDR_W-1:2];
	wire rd_hit_emask  = rd_word == EVENT_MASK_OFFSET[ADDR_W-1:2];
	wire rd_mapped     = rd_hit_status | rd_hit_enable |
	                     rd_hit_event | rd_hit_emask;

	wire [31:0] rd_value =
		rd_hit_status ? global_interrupt_status :
		rd_hit_enable ? global_interrupt_enable_q :
		rd_hit_event  ? event_q :
		rd_hit_emask  ? event_mask_q : RESET_VALUE;

	assign s_axi_arready_o = ~rvalid_q;
	assign s_axi_rvalid_o  = rvalid_q;
	assign s_axi_rdata_o   = rdata_q;
	assign s_axi_rresp_o   = rresp_q;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rvalid_q <= 1'b0;
			rdata_q  <= RESET_VALUE;
			rresp_q  <= RESP_OKAY;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_value;
			rresp_q  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready_i) begin
			rvalid_q <= 1'b0;
		end
	end

endmodule : irq_aggregator

// *** tb/irq_aggregator_asserts.sv ***
// Purpose: Port-level checks of the interrupt aggregator.
// Assumes: One clock domain, asynchronous reset active high.
// Notes:   The status word is rebuilt here from the source requests.
`timescale 1ns/100ps
module irq_aggregator_asserts
	import irq_aggregator_pkg::*;
#(
	parameter int ADDR_W = 18
) (
	input wire logic              clk_i, sys_rst_i,
	input wire source_req_s       src_req_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i, s_axi_araddr_i,
	input wire logic [31:0]       s_axi_wdata_i, s_axi_rdata_o,
	input wire logic [3:0]        s_axi_wstrb_i,
	input wire logic [1:0]        s_axi_bresp_o, s_axi_rresp_o,
	input wire logic              s_axi_awvalid_i, s_axi_awready_o,
	input wire logic              s_axi_wvalid_i, s_axi_wready_o,
	input wire logic              s_axi_bvalid_o, s_axi_bready_i,
	input wire logic              s_axi_arvalid_i, s_axi_arready_o,
	input wire logic              s_axi_rvalid_o, s_axi_rready_i,
	input wire logic              int_pin_o, int_pin_oe_n_o, irq_o
);
	wire logic [7:0]  pr_w;
	wire logic [31:0] st_w;
	assign pr_w = {<<{src_req_i.port_irq}};
	assign st_w = {pr_w, 9'h000, |src_req_i.mcast_latency_err, 6'h00,
		|src_req_i.fabric_port_error, src_req_i.two_wire_irq,
		|src_req_i.mcast_event_irq, |src_req_i.reset_symbol_irq, 4'h0};
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	pin_level_a: assert property (int_pin_o == 1'b0)
		else $error("pin value not low");
	pin_release_a: assert property (st_w == 32'h0 |=> int_pin_oe_n_o)
		else $error("pin driven with no request");
	pin_cause_a: assert property ($fell(int_pin_oe_n_o) |->
		$past(st_w) != 32'h0) else $error("pin fell without cause");
	status_read_a: assert property (s_axi_arvalid_i && s_axi_arready_o &&
		s_axi_araddr_i == STATUS_OFFSET[ADDR_W-1:0] |=>
		s_axi_rdata_o == $past(st_w)) else $error("status word wrong");
	read_latency_a: assert property (s_axi_arvalid_i &&
		s_axi_arready_o |=> s_axi_rvalid_o) else $error("read late");
	read_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
		s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read dropped");
	write_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
		s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("resp dropped");
	read_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("address taken during read answer");

	cover property (!int_pin_oe_n_o);
	cover property (irq_o);
	cover property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR);
endmodule : irq_aggregator_asserts

// *** tb/host_irq_model.sv ***
// Purpose: Host interrupt input seen through the shared pin.
// Assumes: The board holds the line high with a pull-up.
// Notes:   Reports a request while the line is low.
`timescale 1ns/100ps
module host_irq_model (
	input  wire logic pin_i,
	input  wire logic pin_oe_n_i,
	output wire logic irq_seen_o
);
	wire logic line_w;
	// A released line floats to the pull-up level, never to a stale value.
	assign line_w = pin_oe_n_i ? 1'b1 : pin_i;
	assign irq_seen_o = ~line_w;
endmodule : host_irq_model

// *** tb/tb.sv ***
// Purpose: Register and pin tests of the interrupt aggregator.
// Assumes: Bus requests change only just after a rising clock edge.
// Notes:   Handshakes are judged at the rising edge where both sides meet.
`timescale 1ns/100ps
module tb;
	import irq_aggregator_pkg::*;
	logic              clk, rst, awvalid, wvalid, bready, arvalid, rready;
	source_req_s       src;
	logic [17:0]       awaddr, araddr;
	logic [31:0]       wdata, got;
	logic [3:0]        wstrb;
	logic [1:0]        resp;
	wire logic         awready, wready, bvalid, arready, rvalid;
	wire logic         pin, pin_oe_n, irq, host_irq;
	wire logic [31:0]  rdata;
	wire logic [1:0]   bresp, rresp;
	int                mismatches, num_checks;

	irq_aggregator #(.ADDR_W(18)) DUT (.clk_i(clk), .sys_rst_i(rst),
		.src_req_i(src), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .int_pin_o(pin),
		.int_pin_oe_n_o(pin_oe_n), .irq_o(irq));
	host_irq_model host_u (.pin_i(pin), .pin_oe_n_i(pin_oe_n),
		.irq_seen_o(host_irq));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [31:0] a, input logic [31:0] d,
		output logic [1:0] r);
		awaddr  <= a[17:0];
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		// Each channel lets go only at the edge where its own ready is seen.
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge clk); while (!bvalid);
		r = bresp;
	endtask : wr

	task automatic rd(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		araddr  <= a[17:0];
		arvalid <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		d = rdata;
		r = rresp;
	endtask : rd

	// Checks the host's view of the pin and the event interrupt together.
	task automatic lvl(input logic p, input logic i);
		@(negedge clk);
		chk(host_irq, p);
		chk(irq, i);
		@(posedge clk);
	endtask : lvl

	// Status bit expected for a single raised bit of the source vector.
	function automatic logic [31:0] smap(input int i);
		if (i < 8) return 32'h0000_0010;
		if (i < 16) return 32'h0000_0020;
		if (i == 16) return 32'h0000_0040;
		if (i < 25) return 32'h0000_0080;
		if (i < 33) return 32'h0000_4000;
		return 32'h8000_0000 >> (i - 33);
	endfunction : smap

	task automatic summarize;
		if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize

	initial begin
		#200000;
		mismatches++;
		summarize;
	end

	initial begin
		{src, awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
		{wstrb, bready, rready, rst} = 7'h7F;
		mismatches = 0;
		num_checks = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(STATUS_OFFSET, got, resp);
		chk(got, RESET_VALUE);
		rd(ENABLE_OFFSET, got, resp);
		chk(got, RESET_VALUE);
		rd(32'h0001_AC10, got, resp);
		chk(resp, RESP_SLVERR);
		chk(got, 32'h0);
		wr(ENABLE_OFFSET, 32'hFFFF_FFFF, resp);
		chk(resp, RESP_OKAY);
		rd(ENABLE_OFFSET, got, resp);
		chk(got, DEFINED_BITS);
		wr(STATUS_OFFSET, 32'hFFFF_FFFF, resp);
		chk(resp, RESP_OKAY);
		rd(STATUS_OFFSET, got, resp);
		chk(got, 32'h0);
		for (int i = 0; i < 41; i++) begin
			src <= source_req_s'(41'h1 << i);
			wr(ENABLE_OFFSET, DEFINED_BITS & ~smap(i), resp);
			rd(STATUS_OFFSET, got, resp);
			chk(got, smap(i));
			lvl(1'b0, 1'b0);
			wr(ENABLE_OFFSET, smap(i), resp);
			lvl(1'b1, 1'b0);
		end
		src <= '0;
		wr(EVENT_OFFSET, 32'hFFFF_FFFF, resp);
		wr(EVENT_MASK_OFFSET, DEFINED_BITS, resp);
		lvl(1'b0, 1'b0);
		src <= source_req_s'(41'h1 << 16);
		repeat (2) @(posedge clk);
		lvl(1'b0, 1'b1);
		rd(EVENT_OFFSET, got, resp);
		chk(got, 32'h0000_0040);
		wr(EVENT_MASK_OFFSET, DEFINED_BITS & ~32'h0000_0040, resp);
		lvl(1'b0, 1'b0);
		wr(EVENT_MASK_OFFSET, 32'h0000_0040, resp);
		lvl(1'b0, 1'b1);
		src <= '0;
		wr(EVENT_OFFSET, 32'h0000_0040, resp);
		lvl(1'b0, 1'b0);
		// A reset in mid-run with a live, enabled request clears the gate.
		src <= source_req_s'(41'h1 << 40);
		repeat (2) @(posedge clk);
		lvl(1'b1, 1'b0);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(ENABLE_OFFSET, got, resp);
		chk(got, RESET_VALUE);
		lvl(1'b0, 1'b0);
		// Byte lanes without their strobe keep their old contents.
		wstrb <= 4'h8;
		wr(ENABLE_OFFSET, 32'hFFFF_FFFF, resp);
		wstrb <= 4'hF;
		rd(ENABLE_OFFSET, got, resp);
		chk(got, 32'hFF00_0000);
		lvl(1'b1, 1'b0);
		src <= '0;
		summarize;
	end
endmodule : tb

bind irq_aggregator irq_aggregator_asserts #(.ADDR_W(ADDR_W)) chk_u (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .src_req_i(src_req_i),
	.s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_araddr_i(s_axi_araddr_i),
	.s_axi_wdata_i(s_axi_wdata_i), .s_axi_rdata_o(s_axi_rdata_o),
	.s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_bresp_o(s_axi_bresp_o),
	.s_axi_rresp_o(s_axi_rresp_o), .s_axi_awvalid_i(s_axi_awvalid_i),
	.s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
	.s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
	.s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
	.s_axi_rready_i(s_axi_rready_i), .int_pin_o(int_pin_o),
	.int_pin_oe_n_o(int_pin_oe_n_o), .irq_o(irq_o));
